/* File: pkg/pcrc_pkg.sv */
// constants and types shared by the programmable crc control block
package pcrc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] PCRC_OFF_CONTROL = 8'h00;
    localparam logic [7:0] PCRC_OFF_POLY = 8'h04;
    localparam logic [7:0] PCRC_OFF_INPUT = 8'h08;
    localparam logic [7:0] PCRC_OFF_RESULT = 8'h0C;
    localparam logic [7:0] PCRC_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] PCRC_OFF_IRQ_MASK = 8'h14;
    // control register field positions
    localparam int PCRC_BIT_SIDL = 13;
    localparam int PCRC_CNT_HI = 12;
    localparam int PCRC_CNT_LO = 8;
    localparam int PCRC_BIT_FULL = 7;
    localparam int PCRC_BIT_EMPTY = 6;
    localparam int PCRC_BIT_GO = 4;
    localparam int PCRC_LEN_HI = 3;
    localparam int PCRC_LEN_LO = 0;
    // fifo sizing
    localparam int PCRC_DEPTH = 16;
    localparam int PCRC_CNT_W = 5;
    localparam int PCRC_PTR_W = 4;
    localparam logic [4:0] PCRC_CAP_SHORT = 5'h10;
    localparam logic [4:0] PCRC_CAP_LONG = 5'h08;
    localparam logic [3:0] PCRC_LEN_SPLIT = 4'h7;
    // interrupt status bit positions
    localparam int PCRC_IRQ_N = 3;
    localparam int PCRC_IRQ_DONE = 0;
    localparam int PCRC_IRQ_FULL = 1;
    localparam int PCRC_IRQ_OVF = 2;
    // shifter states
    typedef enum logic [1:0] {
        PCRC_IDLE,
        PCRC_LOAD,
        PCRC_SHIFT
    } pcrc_state_t;
endpackage : pcrc_pkg

/* File: src/pcrc_fifo.sv */
// input word fifo with length-dependent capacity
`timescale 1ns/1ps
module pcrc_fifo (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic push, // write one word
    input wire logic [15:0] push_data, // word to write
    input wire logic pop, // consume one word
    input wire logic [pcrc_pkg::PCRC_CNT_W-1:0] cap, // current capacity
    output logic [15:0] head, // oldest word
    output logic [pcrc_pkg::PCRC_CNT_W-1:0] count, // valid words
    output logic full, // count at capacity
    output logic empty, // no words held
    output logic overflow // push refused while full
);
    import pcrc_pkg::*;

    logic [15:0] mem [PCRC_DEPTH];
    logic [PCRC_PTR_W-1:0] wr_r;
    logic [PCRC_PTR_W-1:0] rd_r;
    logic [PCRC_CNT_W-1:0] cnt_r;
    logic do_push;
    logic do_pop;

    // full at capacity, empty at zero
    assign full = (cnt_r >= cap);
    assign empty = (cnt_r == '0);
    assign count = cnt_r;
    assign head = mem[rd_r];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign overflow = push && full;

    // storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_r] <= push_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (do_pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : pcrc_fifo

/* File: src/pcrc_shifter.sv */
// serial crc shifter, one data bit per cycle, msb first
`timescale 1ns/1ps
module pcrc_shifter (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic run, // shifter enabled
    input wire logic word_valid, // a word waits in the fifo
    input wire logic [15:0] word, // word to shift in
    input wire logic [15:0] taps, // polynomial taps
    input wire logic [3:0] len_m1, // polynomial length minus one
    input wire logic res_wr, // software writes the result
    input wire logic [15:0] res_wdata, // value written to result
    output logic take, // pulse: word consumed
    output logic done, // pulse: word fully shifted
    output logic [15:0] result // current remainder
);
    import pcrc_pkg::*;

    pcrc_state_t state_r;
    logic [15:0] data_r;
    logic [3:0] bit_r;
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic fb;

    assign result = crc_r;
    assign take = run && (state_r == PCRC_IDLE) && word_valid;

    // feedback from the top bit of the active length
    always_comb begin
        fb = crc_r[len_m1] ^ data_r[15];
        crc_nxt = {crc_r[14:0], 1'b0};
        if (fb) begin
            crc_nxt = crc_nxt ^ taps;
        end
    end

    // word sequencing; halts in place when run drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= PCRC_IDLE;
            data_r <= '0;
            bit_r <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                PCRC_IDLE: begin
                    if (take) begin
                        data_r <= word;
                        bit_r <= '0;
                        state_r <= PCRC_SHIFT;
                    end
                end
                PCRC_SHIFT: begin
                    if (run) begin
                        data_r <= {data_r[14:0], 1'b0};
                        bit_r <= bit_r + 1'b1;
                        // last bit of the word
                        if (bit_r == '1) begin
                            state_r <= PCRC_IDLE;
                            done <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= PCRC_IDLE;
                end
            endcase
        end
    end

    // remainder register, software may preload it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= '0;
        end else if (res_wr) begin
            crc_r <= res_wdata;
        end else if (run && state_r == PCRC_SHIFT) begin
            crc_r <= crc_nxt;
        end
    end
endmodule : pcrc_shifter

/* File: src/pcrc_top.sv */
// programmable crc control: apb registers, fifo, shifter, interrupt
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pcrc_top (
    input wire logic CLK_SYS, // system clock, 10 MHz
    input wire logic RST_N, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high for write
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic DEVICE_IDLE, // device in idle mode
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    output logic IRQ // level interrupt
);
    import pcrc_pkg::*;

    // apb access strobes
    logic acc;
    logic wr_en;
    logic rd_en;
    logic mapped;

    // software-visible state
    logic sidl_r;
    logic go_r;
    logic [3:0] len_r;
    logic [15:0] taps_r;
    logic [PCRC_IRQ_N-1:0] irq_stat_r;
    logic [PCRC_IRQ_N-1:0] irq_mask_r;
    logic [PCRC_IRQ_N-1:0] irq_ev;
    logic [PCRC_IRQ_N-1:0] irq_stat_nxt;

    // idle synchroniser, four flops
    logic idle_s1_r;
    logic idle_s2_r;
    logic idle_s3_r;
    logic idle_r;

    // datapath wiring
    logic [PCRC_CNT_W-1:0] cap;
    logic [PCRC_CNT_W-1:0] count;
    logic full;
    logic empty;
    logic overflow;
    logic [15:0] head;
    logic take;
    logic done;
    logic [15:0] result;
    logic run;
    logic push;
    logic res_wr;
    logic full_d_r;
    logic [15:0] ctrl_rd;
    logic [31:0] rd_nxt;

    // address match, shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // apb strobes; zero-wait slave
    assign acc = PSEL && PENABLE;
    assign wr_en = acc && PWRITE;
    assign rd_en = acc && !PWRITE;
    assign mapped = hit(PADDR, PCRC_OFF_CONTROL) || hit(PADDR, PCRC_OFF_POLY)
        || hit(PADDR, PCRC_OFF_INPUT) || hit(PADDR, PCRC_OFF_RESULT)
        || hit(PADDR, PCRC_OFF_IRQ_STAT) || hit(PADDR, PCRC_OFF_IRQ_MASK);

    assign push = wr_en && hit(PADDR, PCRC_OFF_INPUT);
    assign res_wr = wr_en && hit(PADDR, PCRC_OFF_RESULT);

    assign run = go_r && !(sidl_r && idle_r);

    assign cap = (len_r > PCRC_LEN_SPLIT) ? PCRC_CAP_LONG : PCRC_CAP_SHORT;

    // idle pin synchroniser; change taken when stages two and three agree
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            idle_s1_r <= 1'b0;
            idle_s2_r <= 1'b0;
            idle_s3_r <= 1'b0;
            idle_r <= 1'b0;
        end else begin
            idle_s1_r <= DEVICE_IDLE;
            idle_s2_r <= idle_s1_r;
            idle_s3_r <= idle_s2_r;
            if (idle_s2_r == idle_s3_r) begin
                idle_r <= idle_s3_r;
            end
        end
    end

    // flags derived from count and capacity
    pcrc_fifo u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .push(push),
        .push_data(PWDATA[15:0]),
        .pop(take),
        .cap(cap),
        .head(head),
        .count(count),
        .full(full),
        .empty(empty),
        .overflow(overflow)
    );

    pcrc_shifter u_shift (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .run(run),
        .word_valid(!empty),
        .word(head),
        .taps(taps_r),
        .len_m1(len_r),
        .res_wr(res_wr),
        .res_wdata(PWDATA[15:0]),
        .take(take),
        .done(done),
        .result(result)
    );

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sidl_r <= 1'b0;
            go_r <= 1'b0;
            len_r <= '0;
            taps_r <= '0;
        end else if (wr_en) begin
            if (hit(PADDR, PCRC_OFF_CONTROL)) begin
                sidl_r <= PWDATA[PCRC_BIT_SIDL];
                go_r <= PWDATA[PCRC_BIT_GO];
                len_r <= PWDATA[PCRC_LEN_HI:PCRC_LEN_LO];
            end else if (hit(PADDR, PCRC_OFF_POLY)) begin
                taps_r <= PWDATA[15:0];
            end
        end
    end

    // interrupt events: word done, fifo became full, push refused
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            full_d_r <= 1'b0;
        end else begin
            full_d_r <= full;
        end
    end

    always_comb begin
        irq_ev = '0;
        irq_ev[PCRC_IRQ_DONE] = done;
        irq_ev[PCRC_IRQ_FULL] = full && !full_d_r;
        irq_ev[PCRC_IRQ_OVF] = overflow;
        irq_stat_nxt = irq_stat_r;
        if (wr_en && hit(PADDR, PCRC_OFF_IRQ_STAT)) begin
            irq_stat_nxt = irq_stat_r & ~PWDATA[PCRC_IRQ_N-1:0];
        end
        // set wins over a clear in the same cycle
        irq_stat_nxt = irq_stat_nxt | irq_ev;
    end

    // sticky status and mask
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_en && hit(PADDR, PCRC_OFF_IRQ_MASK)) begin
                irq_mask_r <= PWDATA[PCRC_IRQ_N-1:0];
            end
        end
    end

    // interrupt output from a flop
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // control read image
    always_comb begin
        ctrl_rd = '0;
        // bits 15, 14, 5 stay zero
        ctrl_rd[PCRC_BIT_SIDL] = sidl_r;
        ctrl_rd[PCRC_CNT_HI:PCRC_CNT_LO] = count;
        ctrl_rd[PCRC_BIT_FULL] = full;
        ctrl_rd[PCRC_BIT_EMPTY] = empty;
        ctrl_rd[PCRC_BIT_GO] = go_r;
        ctrl_rd[PCRC_LEN_HI:PCRC_LEN_LO] = len_r;
    end

    // read decode
    always_comb begin
        rd_nxt = '0;
        if (hit(PADDR, PCRC_OFF_CONTROL)) begin
            rd_nxt = {16'h0000, ctrl_rd};
        end else if (hit(PADDR, PCRC_OFF_POLY)) begin
            rd_nxt = {16'h0000, taps_r};
        end else if (hit(PADDR, PCRC_OFF_RESULT)) begin
            rd_nxt = {16'h0000, result};
        end else if (hit(PADDR, PCRC_OFF_IRQ_STAT)) begin
            rd_nxt[PCRC_IRQ_N-1:0] = irq_stat_r;
        end else if (hit(PADDR, PCRC_OFF_IRQ_MASK)) begin
            rd_nxt[PCRC_IRQ_N-1:0] = irq_mask_r;
        end
    end

    // apb answer: ready registered in the setup phase, high in the first access cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                PREADY <= 1'b1;
                PSLVERR <= !mapped;
                if (!PWRITE) begin
                    PRDATA <= rd_nxt;
                end
            end
        end
    end
endmodule : pcrc_top

/* File: dv/pcrc_monitor.sv */
// port checker for the crc control block
`timescale 1ns/1ps
module pcrc_monitor (
    input wire logic CLK_SYS, // clock
    input wire logic RST_N, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // write
    input wire logic [7:0] PADDR, // address
    input wire logic [31:0] PWDATA, // write data
    input wire logic DEVICE_IDLE, // idle
    input wire logic [31:0] PRDATA, // read data
    input wire logic PREADY, // ready
    input wire logic PSLVERR, // error
    input wire logic IRQ // interrupt
);
    logic [15:0] ctl_r;
    logic rd_ctl;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // a control read completes this cycle
    assign rd_ctl = PREADY && !PWRITE && PADDR == 8'h00;
    // last word written to control
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctl_r <= 16'h0000;
        end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h00) begin
            ctl_r <= PWDATA[15:0];
        end
    end
    ready_after_setup_a: assert property (
        PSEL && !PENABLE |=> PREADY) else $error("no ready");
    ready_single_a: assert property (
        PREADY |=> !PREADY) else $error("ready too long");
    unimpl_zero_a: assert property (
        rd_ctl |-> PRDATA[15:14] == 2'h0 && !PRDATA[5])
        else $error("unused bits set");
    empty_flag_a: assert property (
        rd_ctl |-> PRDATA[6] == (PRDATA[12:8] == 5'h00))
        else $error("empty flag wrong");
    full_flag_a: assert property (
        rd_ctl |-> PRDATA[7] == (PRDATA[12:8] >=
        (PRDATA[3:0] > 4'h7 ? 5'h08 : 5'h10))) else $error("full wrong");
    count_max_a: assert property (
        rd_ctl |-> PRDATA[12:8] <= 5'h10) else $error("count too big");
    len_field_a: assert property (
        rd_ctl |-> PRDATA[3:0] == ctl_r[3:0]) else $error("length lost");
    go_bit_a: assert property (
        rd_ctl |-> PRDATA[4] == ctl_r[4]) else $error("go lost");
    idle_bit_a: assert property (
        rd_ctl |-> PRDATA[13] == ctl_r[13]) else $error("idle bit lost");
endmodule : pcrc_monitor

/* File: dv/pcrc_top_tb.sv */
// self-checking bench for the crc control block
`timescale 1ns/1ps
module pcrc_top_tb;
    import pcrc_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic idle = 1'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic irq;
    logic [31:0] rdat;
    logic [31:0] e;
    logic serr;
    int err_total = 0;
    int comparisons = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    pcrc_top dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pad), .PWDATA(pwd),
        .DEVICE_IDLE(idle), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .IRQ(irq));
    // print counts and verdict, then stop
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // compare seen against expected
    task automatic check(input string nm, input logic [31:0] s,
        input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, x, s);
        end
    endtask : check
    // one apb transfer with bounded wait for ready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'h1 && n < 20);
        rdat = prd;
        serr = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (n >= 20) begin
            err_total++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : xfer
    // read and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'h0, a, 32'h0);
        check("read", rdat, x);
    endtask : rd
    // poll control until it matches, bounded
    task automatic wait_ctl(input logic [15:0] x);
        int n;
        n = 0;
        do begin
            xfer(1'h0, PCRC_OFF_CONTROL, 32'h0);
            n++;
        end while (rdat[15:0] !== x && n < 400);
        check("control", rdat, {16'h0, x});
        if (n >= 400) begin
            report_and_stop();
        end
    endtask : wait_ctl
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(PCRC_OFF_CONTROL, 32'h0040);
        check("irq", irq, 32'h0);
        xfer(1'h1, PCRC_OFF_CONTROL, 32'hFFEF);
        rd(PCRC_OFF_CONTROL, 32'h204F);
        xfer(1'h1, PCRC_OFF_CONTROL, 32'h0007);
        // fill the short-length fifo word by word
        for (int i = 0; i < 16; i++) begin
            xfer(1'h1, PCRC_OFF_INPUT, 32'(i));
            e = 32'h7 | (32'(i + 1) << 8);
            if (i == 15) e = e | 32'h80;
            rd(PCRC_OFF_CONTROL, e);
        end
        xfer(1'h1, PCRC_OFF_INPUT, 32'hABCD);
        rd(PCRC_OFF_CONTROL, 32'h1087);
        rd(PCRC_OFF_IRQ_STAT, 32'h6);
        check("irq", irq, 32'h0);
        xfer(1'h1, PCRC_OFF_IRQ_MASK, 32'h4);
        // irq flop follows the mask one edge after the write lands
        @(posedge clk);
        check("irq", irq, 32'h1);
        xfer(1'h1, PCRC_OFF_IRQ_STAT, 32'h4);
        rd(PCRC_OFF_IRQ_STAT, 32'h2);
        check("irq", irq, 32'h0);
        xfer(1'h1, PCRC_OFF_IRQ_STAT, 32'h2);
        xfer(1'h0, 8'h40, 32'h0);
        check("slverr", serr, 32'h1);
        // taps and result read back, upper half dropped
        xfer(1'h1, PCRC_OFF_POLY, 32'hFFFFA5C3);
        rd(PCRC_OFF_POLY, 32'h0000A5C3);
        xfer(1'h1, PCRC_OFF_RESULT, 32'h00001234);
        rd(PCRC_OFF_RESULT, 32'h00001234);
        rd(PCRC_OFF_INPUT, 32'h0);
        rd(PCRC_OFF_CONTROL, 32'h1087);
        // run the shifter until the fifo drains
        xfer(1'h1, PCRC_OFF_CONTROL, 32'h0017);
        wait_ctl(16'h0057);
        rd(PCRC_OFF_IRQ_STAT, 32'h1);
        xfer(1'h1, PCRC_OFF_IRQ_STAT, 32'h1);
        // long length halves the capacity
        xfer(1'h1, PCRC_OFF_CONTROL, 32'h200F);
        for (int i = 0; i < 8; i++) xfer(1'h1, PCRC_OFF_INPUT, 32'(i));
        rd(PCRC_OFF_CONTROL, 32'h288F);
        // halted while idle, resumes after
        idle <= 1'h1;
        repeat (6) @(posedge clk);
        xfer(1'h1, PCRC_OFF_CONTROL, 32'h201F);
        repeat (60) @(posedge clk);
        rd(PCRC_OFF_CONTROL, 32'h289F);
        idle <= 1'h0;
        wait_ctl(16'h205F);
        // keeps running through idle when stop bit clear
        idle <= 1'h1;
        repeat (6) @(posedge clk);
        xfer(1'h1, PCRC_OFF_CONTROL, 32'h001F);
        xfer(1'h1, PCRC_OFF_INPUT, 32'h1234);
        wait_ctl(16'h005F);
        // second reset in mid-run brings back the power-on image
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(PCRC_OFF_CONTROL, 32'h0040);
        rd(PCRC_OFF_IRQ_STAT, 32'h0);
        check("irq", irq, 32'h0);
        report_and_stop();
    end
endmodule : pcrc_top_tb
bind pcrc_top pcrc_monitor u_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .DEVICE_IDLE(DEVICE_IDLE), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
